// file: pmd_pkg.sv
// Package for the peripheral module disable block: offsets, bit positions,
// implemented-bit masks and the carrier types shared by the design files.
// Assumes a 16-bit register view placed in the low half of a 32-bit bus.
package pmd_pkg;

  localparam int unsigned NUM_REGS = 7;
  localparam int unsigned REG_W = 16;
  localparam int unsigned IDX_W = 3;

  // Byte offsets, one aligned word per register
  localparam logic [7:0] OFS_DIS1 = 8'h00;
  localparam logic [7:0] OFS_DIS2 = 8'h04;
  localparam logic [7:0] OFS_DIS3 = 8'h08;
  localparam logic [7:0] OFS_DIS4 = 8'h0C;
  localparam logic [7:0] OFS_DIS6 = 8'h10;
  localparam logic [7:0] OFS_DIS7 = 8'h14;
  localparam logic [7:0] OFS_DIS8 = 8'h18;
  localparam logic [7:0] OFS_PRESENT = 8'h1C;
  localparam logic [7:0] OFS_ACTIVE = 8'h20;

  // Storage index of each disable register
  localparam logic [2:0] IDX_DIS1 = 3'h0;
  localparam logic [2:0] IDX_DIS2 = 3'h1;
  localparam logic [2:0] IDX_DIS3 = 3'h2;
  localparam logic [2:0] IDX_DIS4 = 3'h3;
  localparam logic [2:0] IDX_DIS6 = 3'h4;
  localparam logic [2:0] IDX_DIS7 = 3'h5;
  localparam logic [2:0] IDX_DIS8 = 3'h6;

  // Bit positions
  localparam int unsigned BIT_ADC = 0;
  localparam int unsigned BIT_CAN = 1;
  localparam int unsigned BIT_CAP_LO = 8;
  localparam int unsigned BIT_CMP_LO = 0;
  localparam int unsigned BIT_COMPARATOR = 10;
  localparam int unsigned BIT_REFCLK = 3;
  localparam int unsigned BIT_CTU = 2;
  localparam int unsigned BIT_PWM_LO = 8;
  localparam int unsigned BIT_DMA = 4;
  localparam int unsigned BIT_SENT_B = 12;
  localparam int unsigned BIT_SENT_A = 11;
  localparam int unsigned BIT_DEADMAN = 8;

  // Implemented-bit masks; bits outside read zero and ignore writes
  localparam logic [15:0] MASK_DIS1 = 16'h0003;
  localparam logic [15:0] MASK_DIS2 = 16'h0F0F;
  localparam logic [15:0] MASK_DIS3 = 16'h0400;
  localparam logic [15:0] MASK_DIS4 = 16'h000C;
  localparam logic [15:0] MASK_DIS6 = 16'h0700;
  localparam logic [15:0] MASK_DIS7 = 16'h0010;
  localparam logic [15:0] MASK_DIS8 = 16'h1900;
  localparam logic [15:0] RESET_DIS = 16'h0000;

  // Top module index; gate vectors are NUM_MOD+1 bits wide
  localparam int unsigned NUM_MOD = 19;
  // Position of each module in the gate vectors
  localparam int unsigned M_ADC = 0;
  localparam int unsigned M_CAN = 1;
  localparam int unsigned M_CAP = 2;
  localparam int unsigned M_CMP = 6;
  localparam int unsigned M_COMPARATOR = 10;
  localparam int unsigned M_REFCLK = 11;
  localparam int unsigned M_CTU = 12;
  localparam int unsigned M_PWM = 13;
  localparam int unsigned M_DMA = 16;
  localparam int unsigned M_SENT_A = 17;
  localparam int unsigned M_SENT_B = 18;
  localparam int unsigned M_DEADMAN = 19;

  localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
  } bus_req_t;

  typedef struct packed {
    logic [NUM_MOD:0] clk_en;
    logic [NUM_MOD:0] reg_en;
  } gate_t;

endpackage : pmd_pkg

// file: pmd_regfile.sv
// Small register store for the seven disable registers.
// Assumes writes are already masked by the caller; read data is registered.
`timescale 1ns/100ps
module pmd_regfile
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [2:0] wr_idx,
  input wire logic [15:0] wr_data,
  input wire logic [2:0] rd_idx,
  output logic [15:0] rd_data,
  output logic [16*pmd_pkg::NUM_REGS-1:0] all_q
);

  logic [15:0] mem_r [pmd_pkg::NUM_REGS];

  genvar g;
  generate
    for (g = 0; g < pmd_pkg::NUM_REGS; g++)
    begin : g_word
      always_ff @(posedge clk)
      begin
        if (rst)
          mem_r[g] <= pmd_pkg::RESET_DIS;
        else if (ce && wr_en && wr_idx == 3'(g))
          mem_r[g] <= wr_data;
      end
      assign all_q[16*g +: 16] = mem_r[g];
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (rst)
      rd_data <= pmd_pkg::RESET_DIS;
    else if (ce)
      rd_data <= (int'(rd_idx) < pmd_pkg::NUM_REGS) ? mem_r[rd_idx]
                                                     : pmd_pkg::RESET_DIS;
  end

endmodule : pmd_regfile

// file: peripheral_module_disable.sv
// Peripheral module disable block: seven software disable registers on an
// Avalon-MM slave, driving per-module clock and register-access enables.
// Assumes a synchronous bus master on CLK_SYS and module presence straps.
`timescale 1ns/100ps

// Functional notes
// R1 - Unimplemented bits read zero, ignore writes
// R2 - CAN disable at register 1 bit 1
// R3 - ADC disable at register 1 bit 0
// R4 - Capture disables at register 2 bits 11-8
// R5 - Compare disables at register 2 bits 3-0
// R6 - Comparator disable at register 3 bit 10
// R7 - Reference clock disable at register 4 bit 3
// R8 - Charge time unit disable at register 4 bit 2
// R9 - PWM generator disables at register 6 bits 10-8
// R10 - One DMA bit at register 7 bit 4
// R11 - Second SENT disable at register 8 bit 12
// R12 - First SENT disable at register 8 bit 11
// R13 - Deadman timer disable at register 8 bit 8
// R14 - One turns module off, zero on
// R15 - Disable bits read/write, zero after reset
// R16 - Disabled module: clocks stopped, registers blocked
// R17 - Change reaches module one cycle later
// R18 - Active only if enabled and present
// R19 - Sixteen-bit registers, single-cycle bus access; reads take one wait state
module peripheral_module_disable
(
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic CE,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic [pmd_pkg::NUM_MOD:0] MODULE_PRESENT,
  output pmd_pkg::gate_t MODULE_GATE
);

  localparam int unsigned NM = pmd_pkg::NUM_MOD + 1;

  pmd_pkg::bus_req_t req;
  logic [15:0] wmask;
  logic [2:0] widx;
  logic wsel;
  logic [15:0] wdata;
  logic [15:0] rf_rd;
  logic [16*pmd_pkg::NUM_REGS-1:0] rf_all;
  logic [15:0] d1, d2, d3, d4, d6, d7, d8;
  logic [NM-1:0] off_vec;
  logic [NM-1:0] active_nxt;
  logic [NM-1:0] active_r;
  logic [NM-1:0] present_r;
  logic rd_pend_r;
  logic [1:0] rd_kind_r;
  logic [NM-1:0] stat_r;

  assign req = '{read: AVS_READ, write: AVS_WRITE,
                 address: AVS_ADDRESS, writedata: AVS_WRITEDATA};

  // Decode used for both the write path and the read path
  function automatic logic [19:0] decode(input logic [7:0] a);
    logic [19:0] r;
    r = '0;
    if (a == pmd_pkg::OFS_DIS1)
      r = {1'b1, pmd_pkg::IDX_DIS1, pmd_pkg::MASK_DIS1};
    else if (a == pmd_pkg::OFS_DIS2)
      r = {1'b1, pmd_pkg::IDX_DIS2, pmd_pkg::MASK_DIS2};
    else if (a == pmd_pkg::OFS_DIS3)
      r = {1'b1, pmd_pkg::IDX_DIS3, pmd_pkg::MASK_DIS3};
    else if (a == pmd_pkg::OFS_DIS4)
      r = {1'b1, pmd_pkg::IDX_DIS4, pmd_pkg::MASK_DIS4};
    else if (a == pmd_pkg::OFS_DIS6)
      r = {1'b1, pmd_pkg::IDX_DIS6, pmd_pkg::MASK_DIS6};
    else if (a == pmd_pkg::OFS_DIS7)
      r = {1'b1, pmd_pkg::IDX_DIS7, pmd_pkg::MASK_DIS7};
    else if (a == pmd_pkg::OFS_DIS8)
      r = {1'b1, pmd_pkg::IDX_DIS8, pmd_pkg::MASK_DIS8};
    return r;
  endfunction : decode

  assign {wsel, widx, wmask} = decode(req.address);

  // Byte lanes 0 and 1 carry the register; masked bits keep zero
  always_comb
  begin
    wdata = rf_all[16*widx +: 16];
    if (AVS_BYTEENABLE[0])
      wdata[7:0] = req.writedata[7:0];
    if (AVS_BYTEENABLE[1])
      wdata[15:8] = req.writedata[15:8];
    wdata = wdata & wmask; // R1
  end

  pmd_regfile u_regs
  (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .ce(CE),
    .wr_en(req.write && wsel), // R15
    .wr_idx(widx),
    .wr_data(wdata),
    .rd_idx(widx),
    .rd_data(rf_rd),
    .all_q(rf_all)
  );

  assign d1 = rf_all[16*pmd_pkg::IDX_DIS1 +: 16];
  assign d2 = rf_all[16*pmd_pkg::IDX_DIS2 +: 16];
  assign d3 = rf_all[16*pmd_pkg::IDX_DIS3 +: 16];
  assign d4 = rf_all[16*pmd_pkg::IDX_DIS4 +: 16];
  assign d6 = rf_all[16*pmd_pkg::IDX_DIS6 +: 16];
  assign d7 = rf_all[16*pmd_pkg::IDX_DIS7 +: 16];
  assign d8 = rf_all[16*pmd_pkg::IDX_DIS8 +: 16];

  // Gather each module's disable bit into one vector
  always_comb
  begin
    off_vec = '0;
    off_vec[pmd_pkg::M_ADC] = d1[pmd_pkg::BIT_ADC]; // R3
    off_vec[pmd_pkg::M_CAN] = d1[pmd_pkg::BIT_CAN]; // R2
    off_vec[pmd_pkg::M_CAP +: 4] = d2[pmd_pkg::BIT_CAP_LO +: 4]; // R4
    off_vec[pmd_pkg::M_CMP +: 4] = d2[pmd_pkg::BIT_CMP_LO +: 4]; // R5
    off_vec[pmd_pkg::M_COMPARATOR] = d3[pmd_pkg::BIT_COMPARATOR]; // R6
    off_vec[pmd_pkg::M_REFCLK] = d4[pmd_pkg::BIT_REFCLK]; // R7
    off_vec[pmd_pkg::M_CTU] = d4[pmd_pkg::BIT_CTU]; // R8
    off_vec[pmd_pkg::M_PWM +: 3] = d6[pmd_pkg::BIT_PWM_LO +: 3]; // R9
    off_vec[pmd_pkg::M_DMA] = d7[pmd_pkg::BIT_DMA]; // R10
    off_vec[pmd_pkg::M_SENT_A] = d8[pmd_pkg::BIT_SENT_A]; // R12
    off_vec[pmd_pkg::M_SENT_B] = d8[pmd_pkg::BIT_SENT_B]; // R11
    off_vec[pmd_pkg::M_DEADMAN] = d8[pmd_pkg::BIT_DEADMAN]; // R13
  end

  // Straps are caught after reset by a clocked load, never by the reset
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
      present_r <= '0;
    else if (CE)
      present_r <= MODULE_PRESENT;
  end

  always_comb
  begin
    active_nxt = ~off_vec & present_r; // R14 R18
  end

  // One extra register stage gives the one-cycle settling delay
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
      active_r <= '0;
    else if (CE)
      active_r <= active_nxt; // R17
  end

  // Clock and register access both follow the same gate
  assign MODULE_GATE = '{clk_en: active_r, reg_en: active_r}; // R16

  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
      stat_r <= '0;
    else if (CE)
      stat_r <= present_r;
  end

  // Reads answer one cycle after the request; a low CE stalls both kinds
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      rd_pend_r <= 1'b0;
      rd_kind_r <= 2'h0;
    end
    else if (CE)
    begin
      rd_pend_r <= req.read && !rd_pend_r; // R19
      if (wsel)
        rd_kind_r <= 2'h1;
      else if (req.address == pmd_pkg::OFS_PRESENT)
        rd_kind_r <= 2'h2;
      else if (req.address == pmd_pkg::OFS_ACTIVE)
        rd_kind_r <= 2'h3;
      else
        rd_kind_r <= 2'h0;
    end
  end

  assign AVS_WAITREQUEST = (req.read && !rd_pend_r)
                           || ((req.read || req.write) && !CE);

  always_comb
  begin
    case (rd_kind_r)
      2'h1: AVS_READDATA = {16'h0000, rf_rd}; // R1
      2'h2: AVS_READDATA = 32'(stat_r);
      2'h3: AVS_READDATA = 32'(active_r);
      default: AVS_READDATA = pmd_pkg::READ_UNMAPPED;
    endcase
  end

  sequence s_bit_set(int b);
    req.write && wsel && widx == pmd_pkg::IDX_DIS1 && CE
      && req.writedata[b] && AVS_BYTEENABLE[0];
  endsequence

  // The write lands, then one enabled edge moves the gate
  sequence s_set_then_run(int b);
    s_bit_set(b) ##1 CE;
  endsequence

  // A set disable bit closes both gates at the next enabled edge
  property p_bit_gates(logic off_bit, int m);
    @(posedge CLK_SYS) disable iff (SYS_RST)
    off_bit && CE |=> !MODULE_GATE.clk_en[m] && !MODULE_GATE.reg_en[m];
  endproperty

  a_adc_gate_off: assert property ( // R3
    @(posedge CLK_SYS) disable iff (SYS_RST)
    s_set_then_run(0) |=> !MODULE_GATE.clk_en[pmd_pkg::M_ADC])
    else $error("ADC gate did not close after disable write");

  a_can_gate_off: assert property ( // R2
    @(posedge CLK_SYS) disable iff (SYS_RST)
    s_set_then_run(1) |=> !MODULE_GATE.reg_en[pmd_pkg::M_CAN])
    else $error("CAN gate did not close after disable write");

  a_unimpl_zero: assert property ( // R1
    @(posedge CLK_SYS) disable iff (SYS_RST)
    rd_kind_r == 2'h1 && req.read && !AVS_WAITREQUEST
      |-> (AVS_READDATA & ~{16'h0000, wmask}) == 32'h0000_0000)
    else $error("Unimplemented bit of a disable register read non-zero");

  a_reserved_bits: assert property ( // R1
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (d3 & ~pmd_pkg::MASK_DIS3) == 16'h0000
    && (d8 & ~pmd_pkg::MASK_DIS8) == 16'h0000)
    else $error("Unimplemented bit holds a value");

  a_gate_delay: assert property ( // R17
    @(posedge CLK_SYS) disable iff (SYS_RST)
    CE |=> active_r == $past(active_nxt))
    else $error("Gate did not follow disable bits after one cycle");

  a_absent_off: assert property ( // R18
    @(posedge CLK_SYS) disable iff (SYS_RST)
    !present_r[pmd_pkg::M_DMA] && CE |=> !active_r[pmd_pkg::M_DMA])
    else $error("Absent DMA module shown active");

  a_dma_shared: assert property ( // R10
    @(posedge CLK_SYS) disable iff (SYS_RST)
    d7[pmd_pkg::BIT_DMA] && CE |=> !MODULE_GATE.clk_en[pmd_pkg::M_DMA])
    else $error("DMA clock runs while disabled");

  a_read_answer: assert property ( // R19
    @(posedge CLK_SYS) disable iff (SYS_RST)
    req.read && CE && !rd_pend_r |=> !AVS_WAITREQUEST || !CE)
    else $error("Read not answered in one cycle");

  a_reset_clear: assert property ( // R15
    @(posedge CLK_SYS)
    $fell(SYS_RST) |-> rf_all == '0)
    else $error("Disable registers not zero after reset");

  // Each implemented bit gates its own module
  a_cap1_gate_off: assert property ( // R4
    p_bit_gates(d2[pmd_pkg::BIT_CAP_LO], pmd_pkg::M_CAP))
    else $error("Capture unit 1 runs while disabled");

  a_cap2_gate_off: assert property ( // R4
    p_bit_gates(d2[pmd_pkg::BIT_CAP_LO + 1], pmd_pkg::M_CAP + 1))
    else $error("Capture unit 2 runs while disabled");

  a_cap3_gate_off: assert property ( // R4
    p_bit_gates(d2[pmd_pkg::BIT_CAP_LO + 2], pmd_pkg::M_CAP + 2))
    else $error("Capture unit 3 runs while disabled");

  a_cap4_gate_off: assert property ( // R4
    p_bit_gates(d2[pmd_pkg::BIT_CAP_LO + 3], pmd_pkg::M_CAP + 3))
    else $error("Capture unit 4 runs while disabled");

  a_cmp1_gate_off: assert property ( // R5
    p_bit_gates(d2[pmd_pkg::BIT_CMP_LO], pmd_pkg::M_CMP))
    else $error("Compare unit 1 runs while disabled");

  a_cmp2_gate_off: assert property ( // R5
    p_bit_gates(d2[pmd_pkg::BIT_CMP_LO + 1], pmd_pkg::M_CMP + 1))
    else $error("Compare unit 2 runs while disabled");

  a_cmp3_gate_off: assert property ( // R5
    p_bit_gates(d2[pmd_pkg::BIT_CMP_LO + 2], pmd_pkg::M_CMP + 2))
    else $error("Compare unit 3 runs while disabled");

  a_cmp4_gate_off: assert property ( // R5
    p_bit_gates(d2[pmd_pkg::BIT_CMP_LO + 3], pmd_pkg::M_CMP + 3))
    else $error("Compare unit 4 runs while disabled");

  a_comparator_off: assert property ( // R6
    p_bit_gates(d3[pmd_pkg::BIT_COMPARATOR], pmd_pkg::M_COMPARATOR))
    else $error("Comparator runs while disabled");

  a_refclk_off: assert property ( // R7
    p_bit_gates(d4[pmd_pkg::BIT_REFCLK], pmd_pkg::M_REFCLK))
    else $error("Reference clock output runs while disabled");

  a_ctu_gate_off: assert property ( // R8
    p_bit_gates(d4[pmd_pkg::BIT_CTU], pmd_pkg::M_CTU))
    else $error("Charge time unit runs while disabled");

  a_pwm1_gate_off: assert property ( // R9
    p_bit_gates(d6[pmd_pkg::BIT_PWM_LO], pmd_pkg::M_PWM))
    else $error("PWM generator 1 runs while disabled");

  a_pwm2_gate_off: assert property ( // R9
    p_bit_gates(d6[pmd_pkg::BIT_PWM_LO + 1], pmd_pkg::M_PWM + 1))
    else $error("PWM generator 2 runs while disabled");

  a_pwm3_gate_off: assert property ( // R9
    p_bit_gates(d6[pmd_pkg::BIT_PWM_LO + 2], pmd_pkg::M_PWM + 2))
    else $error("PWM generator 3 runs while disabled");

  a_sent_b_off: assert property ( // R11
    p_bit_gates(d8[pmd_pkg::BIT_SENT_B], pmd_pkg::M_SENT_B))
    else $error("Second SENT interface runs while disabled");

  a_sent_a_off: assert property ( // R12
    p_bit_gates(d8[pmd_pkg::BIT_SENT_A], pmd_pkg::M_SENT_A))
    else $error("First SENT interface runs while disabled");

  a_deadman_off: assert property ( // R13
    p_bit_gates(d8[pmd_pkg::BIT_DEADMAN], pmd_pkg::M_DEADMAN))
    else $error("Deadman timer runs while disabled");

  a_adc_runs: assert property ( // R14
    @(posedge CLK_SYS) disable iff (SYS_RST)
    !d1[pmd_pkg::BIT_ADC] && present_r[pmd_pkg::M_ADC] && CE
      |=> MODULE_GATE.clk_en[pmd_pkg::M_ADC])
    else $error("Present ADC stays off with its bit clear");

  a_write_no_wait: assert property ( // R19
    @(posedge CLK_SYS) disable iff (SYS_RST)
    req.write && !req.read && CE |-> !AVS_WAITREQUEST)
    else $error("Write was made to wait");

  // A frozen block must not let the master believe a write landed
  a_stall_frozen: assert property ( // R19
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (req.read || req.write) && !CE |-> AVS_WAITREQUEST)
    else $error("Bus answered while the block was frozen");

endmodule : peripheral_module_disable

// file: gated_module_bank.sv
// Far-side model: the gated ADC module and the presence straps of all modules.
// Assumes the gate vector from the disable block and one system clock.
`timescale 1ns/100ps
module gated_module_bank
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [pmd_pkg::NUM_MOD:0] strap,
  input wire pmd_pkg::gate_t gate,
  output logic [pmd_pkg::NUM_MOD:0] present,
  output logic [15:0] adc_ticks
);
  // Straps are fixed wiring of the device variant
  assign present = strap;
  // A stopped clock must freeze the module, so its tick count shows it
  always_ff @(posedge clk)
  begin
    if (rst)
      adc_ticks <= 16'h0000;
    else if (gate.clk_en[0] && gate.reg_en[0])
      adc_ticks <= adc_ticks + 16'h0001;
  end
endmodule : gated_module_bank

// file: peripheral_module_disable_tb.sv
// Testbench for the peripheral module disable block over Avalon-MM.
// Assumes the far-side model; CE drops once to check the freeze.
`timescale 1ns/100ps
module peripheral_module_disable_tb;
  logic CLK_SYS, SYS_RST, CE, AVS_READ, AVS_WRITE, AVS_WAITREQUEST;
  logic [7:0] AVS_ADDRESS;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA, q;
  logic [3:0] AVS_BYTEENABLE;
  logic [19:0] strap, present;
  pmd_pkg::gate_t gate;
  logic [15:0] ticks, t0;
  int fail_count, check_count;
  logic [7:0] ofs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
  logic [15:0] msk [7] = '{16'h0003, 16'h0F0F, 16'h0400, 16'h000C,
                           16'h0700, 16'h0010, 16'h1900};
  // Single-bit cases: register offset, bit, gate index
  logic [7:0] s_ofs [6] = '{8'h00, 8'h14, 8'h18, 8'h04, 8'h0C, 8'h18};
  int s_bit [6] = '{0, 4, 8, 8, 3, 12};
  int s_mod [6] = '{0, 16, 19, 2, 11, 18};

  peripheral_module_disable uut
  (
    .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .CE(CE),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .MODULE_PRESENT(present), .MODULE_GATE(gate)
  );

  gated_module_bank farside
  (
    .clk(CLK_SYS), .rst(SYS_RST), .strap(strap), .gate(gate),
    .present(present), .adc_ticks(ticks)
  );

  initial
  begin
    CLK_SYS = 1'b0;
    forever #4 CLK_SYS = ~CLK_SYS;
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %0t read %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_gate(input logic [19:0] got, input logic [19:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %0t gate %h expected %h", $time, got, exp);
    end
  endtask : chk_gate

  // Holds the request until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [15:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge CLK_SYS);
    AVS_ADDRESS <= a;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    AVS_WRITEDATA <= {16'h0000, d};
    AVS_BYTEENABLE <= be;
    do
    begin
      @(posedge CLK_SYS);
      n++;
    end while (AVS_WAITREQUEST !== 1'b0 && n < 20);
    if (n >= 20)
    begin
      fail_count++;
      $display("ERROR %0t bus answer missing", $time);
    end
    q = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask : bus

  task automatic settle;
    repeat (3) @(posedge CLK_SYS);
    #1;
  endtask : settle

  initial
  begin
    SYS_RST = 1'b1;
    CE = 1'b1;
    AVS_READ = 1'b0;
    AVS_WRITE = 1'b0;
    AVS_ADDRESS = 8'h00;
    AVS_WRITEDATA = 32'h0000_0000;
    AVS_BYTEENABLE = 4'h3;
    strap = 20'hFFFFF;
    fail_count = 0;
    check_count = 0;
    repeat (10) @(posedge CLK_SYS);
    SYS_RST <= 1'b0;
    for (int i = 0; i < 7; i++)
    begin
      bus(1'b0, ofs[i], 16'h0000, 4'h3);
      chk(q, 32'h0000_0000);
    end
    settle();
    chk_gate(gate.clk_en, 20'hFFFFF);
    $display("reset values done");
    for (int i = 0; i < 7; i++)
    begin
      bus(1'b1, ofs[i], 16'hFFFF, 4'h3);
      bus(1'b0, ofs[i], 16'h0000, 4'h3);
      chk(q, {16'h0000, msk[i]});
    end
    settle();
    chk_gate(gate.clk_en, 20'h00000);
    chk_gate(gate.reg_en, 20'h00000);
    t0 = ticks;
    settle();
    chk(ticks, t0);
    for (int i = 0; i < 7; i++)
      bus(1'b1, ofs[i], 16'h0000, 4'h3);
    settle();
    chk_gate(gate.clk_en, 20'hFFFFF);
    t0 = ticks;
    settle();
    chk(ticks, t0 + 16'h0003);
    $display("all bits done");
    for (int i = 0; i < 6; i++)
    begin
      bus(1'b1, s_ofs[i], 16'h0001 << s_bit[i], 4'h3);
      #1;
      chk_gate(gate.clk_en, 20'hFFFFF);
      @(posedge CLK_SYS);
      #1;
      chk_gate(gate.clk_en, ~(20'h00001 << s_mod[i]));
      chk_gate(gate.reg_en, ~(20'h00001 << s_mod[i]));
      bus(1'b1, s_ofs[i], 16'h0000, 4'h3);
    end
    $display("single bits done");
    @(posedge CLK_SYS);
    strap <= 20'hEFFFE;
    settle();
    chk_gate(gate.clk_en, 20'hEFFFE);
    bus(1'b0, 8'h1C, 16'h0000, 4'h3);
    chk(q, 32'h000E_FFFE);
    bus(1'b0, 8'h20, 16'h0000, 4'h3);
    chk(q, 32'h000E_FFFE);
    @(posedge CLK_SYS);
    CE <= 1'b0;
    strap <= 20'hFFFFF;
    fork
      bus(1'b1, 8'h14, 16'h0010, 4'h3);
      begin
        settle();
        chk_gate(gate.clk_en, 20'hEFFFE);
        @(posedge CLK_SYS);
        CE <= 1'b1;
      end
    join
    settle();
    chk_gate(gate.clk_en, 20'hEFFFF);
    bus(1'b1, 8'h14, 16'h0000, 4'h3);
    $display("presence and freeze done");
    bus(1'b1, 8'h04, 16'hFFFF, 4'h1);
    bus(1'b0, 8'h04, 16'h0000, 4'h3);
    chk(q, 32'h0000_000F);
    bus(1'b1, 8'h04, 16'hFFFF, 4'h2);
    bus(1'b0, 8'h04, 16'h0000, 4'h3);
    chk(q, 32'h0000_0F0F);
    bus(1'b1, 8'h04, 16'h0000, 4'h3);
    bus(1'b1, 8'h3C, 16'hFFFF, 4'h3);
    bus(1'b0, 8'h3C, 16'h0000, 4'h3);
    chk(q, 32'h0000_0000);
    $display("lanes and unmapped done");
    close_out();
  end

  initial
  begin
    #20000;
    fail_count++;
    $display("ERROR %0t watchdog expired", $time);
    close_out();
  end
endmodule : peripheral_module_disable_tb
